// File: inc/fps_pkg.sv
// constants, field layout and decode helpers for the flash protection/status block
// assumes a 32-bit axi4-lite register port, 16-bit flash addresses
package fps_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONFIG   = 8'h03;
    localparam logic [7:0] IDX_PROT     = 8'h04;
    localparam logic [7:0] IDX_STAT     = 8'h05;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
    localparam logic [7:0] IDX_IRQ_CLR  = 8'h09;
    localparam logic [7:0] IDX_IRQ_EN   = 8'h0a;
    // protection register fields
    localparam int PROT_POLARITY = 7;
    localparam int PROT_NV6      = 6;
    localparam int PROT_HDIS     = 5;
    localparam int PROT_HS_LSB   = 3;
    localparam int PROT_LDIS     = 2;
    localparam int PROT_LS_LSB   = 0;
    // status register fields
    localparam int STAT_BUFFER_EMPTY_FLAG = 7;
    localparam int STAT_COMMAND_COMPLETE_FLAG  = 6;
    localparam int STAT_PROTECT_VIOLATION_FLAG = 5;
    localparam int STAT_ACC   = 4;
    localparam int STAT_BLANK = 2;
    localparam int STAT_FAIL  = 1;
    localparam int STAT_DONE  = 0;
    // config register fields
    localparam int CFG_BUFFER_EMPTY_IRQ_ENABLE = 7;
    localparam int CFG_COMPLETE_IRQ_ENABLE  = 6;
    // event status bits
    localparam int EV_BUFFER_EMPTY_FLAG = 0;
    localparam int EV_COMMAND_COMPLETE_FLAG  = 1;
    localparam int EV_ACC   = 2;
    localparam int EV_PROTECT_VIOLATION_FLAG = 3;
    localparam int EV_W     = 4;
    // reset values, low window start and response codes
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] PROT_RST   = 8'hff;
    localparam logic [15:0] LOW_START = 16'h4000;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // allowed target scenarios, one mask per source scenario
    localparam logic [7:0] SCEN_MASK [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08,
                                             8'h18, 8'h3c, 8'h5a, 8'hff};

    function automatic logic [2:0] scen_of(input logic [7:0] p);
        scen_of = {p[PROT_POLARITY], p[PROT_HDIS], p[PROT_LDIS]};
    endfunction

    function automatic logic scen_allowed(input logic [2:0] from, input logic [2:0] to);
        scen_allowed = SCEN_MASK[from][to];
    endfunction

    function automatic logic [15:0] high_start(input logic [1:0] sz);
        case (sz)
            2'b00:   high_start = 16'hf800;
            2'b01:   high_start = 16'hf000;
            2'b10:   high_start = 16'he000;
            default: high_start = 16'hc000;
        endcase
    endfunction

    function automatic logic [15:0] low_end(input logic [1:0] sz);
        case (sz)
            2'b00:   low_end = 16'h43ff;
            2'b01:   low_end = 16'h47ff;
            2'b10:   low_end = 16'h4fff;
            default: low_end = 16'h5fff;
        endcase
    endfunction
endpackage

// File: logic/fps_flash_protect.sv
// flash range protection and command status registers behind an axi4-lite slave
// assumes a command engine outside that reports done/fail/blank/violation pulses
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
module fps_flash_protect
    import fps_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // device mode and nonvolatile setting
    input  wire logic        special_mode,
    input  wire logic [7:0]  nv_protection,
    // command engine
    input  wire logic        flash_word_wr,
    input  wire logic        cmd_done,
    input  wire logic        cmd_fail,
    input  wire logic        cmd_blank,
    input  wire logic        cmd_violation,
    output logic             cmd_launch,
    output logic             cmd_active,
    // protection lookup
    input  wire logic [15:0] probe_addr,
    output logic             addr_protected,
    // interrupt
    output logic             irq
);
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        aw_held_q, w_held_q;
    logic [7:0]  aw_idx_q;
    logic        aw_bad_q;
    logic [7:0]  wd_q;
    logic        wstb_q;
    logic [7:0]  prot_q, config_q;
    logic        load_pending_q;
    logic        buffer_empty_flag_q, command_complete_flag_q, protect_violation_flag_q, access_error_flag_q, blank_q, fail_q;
    logic        seq_active_q, busy_q, buffered_q, launch_q;
    logic [EV_W-1:0] ev_stat_q, ev_en_q;
    logic        irq_q, prot_hit_q;
    logic        buffer_empty_flag_prev_q, command_complete_flag_prev_q;
    logic        wr_fire, wr_prot, wr_stat, launch_ok, abort;
    logic [2:0]  scen_new;

    assign awready        = awready_q;
    assign wready         = wready_q;
    assign bvalid         = bvalid_q;
    assign bresp          = bresp_q;
    assign arready        = arready_q;
    assign rvalid         = rvalid_q;
    assign rdata          = rdata_q;
    assign rresp          = rresp_q;
    assign cmd_launch     = launch_q;
    assign cmd_active     = busy_q;
    assign addr_protected = prot_hit_q;
    assign irq            = irq_q;

    function automatic logic idx_known(input logic [7:0] idx);
        idx_known = (idx == IDX_CONFIG) || (idx == IDX_PROT) || (idx == IDX_STAT) ||
                    (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_CLR) || (idx == IDX_IRQ_EN);
    endfunction

    // write channel: address and data taken in either order, answered together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_idx_q  <= 8'h00;
            aw_bad_q  <= 1'b0;
            wd_q      <= 8'h00;
            wstb_q    <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_held_q <= 1'b1;
                // a bad address parks on an index that decodes to nothing
                aw_idx_q  <= (awaddr[31:10] != 22'h0 || awaddr[1:0] != 2'b00) ?
                             8'hff : awaddr[9:2];
                aw_bad_q  <= (awaddr[31:10] != 22'h0) || (awaddr[1:0] != 2'b00) ||
                             !idx_known(awaddr[9:2]);
            end
            if (wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_held_q <= 1'b1;
                wd_q     <= wdata[7:0];
                wstb_q   <= wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= aw_bad_q ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_q && bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    assign wr_fire  = aw_held_q && w_held_q && !bvalid_q;
    assign wr_prot  = wr_fire && wstb_q && (aw_idx_q == IDX_PROT) && !load_pending_q;
    assign wr_stat  = wr_fire && wstb_q && (aw_idx_q == IDX_STAT);
    assign scen_new = {wd_q[PROT_POLARITY], wd_q[PROT_HDIS], wd_q[PROT_LDIS]};
    // launch blocked by any pending error flag
    assign launch_ok = wr_stat && wd_q[STAT_BUFFER_EMPTY_FLAG] && buffer_empty_flag_q && seq_active_q &&
                       !access_error_flag_q && !protect_violation_flag_q && !fail_q;
    assign abort     = wr_stat && !wd_q[STAT_BUFFER_EMPTY_FLAG] && buffer_empty_flag_q && seq_active_q;

    // read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
        end else begin
            if (arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rresp_q   <= RESP_OKAY;
                rdata_q   <= 32'h0;
                if ((araddr[31:10] != 22'h0) || (araddr[1:0] != 2'b00)) begin
                    rresp_q <= RESP_SLVERR;
                end else if (araddr[9:2] == IDX_CONFIG) begin
                    rdata_q[7:0] <= config_q;
                end else if (araddr[9:2] == IDX_PROT) begin
                    rdata_q[7:0] <= prot_q;
                end else if (araddr[9:2] == IDX_STAT) begin
                    rdata_q[7:0] <= {buffer_empty_flag_q, command_complete_flag_q, protect_violation_flag_q, access_error_flag_q, 1'b0, blank_q,
                                     special_mode && fail_q,
                                     special_mode && !busy_q};
                end else if (araddr[9:2] == IDX_IRQ_STAT) begin
                    rdata_q[EV_W-1:0] <= ev_stat_q;
                end else if (araddr[9:2] == IDX_IRQ_EN) begin
                    rdata_q[EV_W-1:0] <= ev_en_q;
                end else if (araddr[9:2] != IDX_IRQ_CLR) begin
                    rresp_q <= RESP_SLVERR;
                end
            end
            if (rvalid_q && rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // protection register: nonvolatile copy first, then only added protection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prot_q         <= PROT_RST;
            load_pending_q <= 1'b1;
        end else if (load_pending_q) begin
            prot_q         <= nv_protection;
            load_pending_q <= 1'b0;
        end else if (wr_prot && scen_allowed(scen_of(prot_q), scen_new)) begin
            prot_q[PROT_POLARITY] <= wd_q[PROT_POLARITY];
            prot_q[PROT_HDIS]     <= wd_q[PROT_HDIS];
            prot_q[PROT_LDIS]     <= wd_q[PROT_LDIS];
            if (prot_q[PROT_HDIS]) begin
                prot_q[PROT_HS_LSB+:2] <= wd_q[PROT_HS_LSB+:2];
            end
            if (prot_q[PROT_LDIS]) begin
                prot_q[PROT_LS_LSB+:2] <= wd_q[PROT_LS_LSB+:2];
            end
        end
    end

    // address lookup against the active windows
    always_ff @(posedge aclk) begin
        logic in_hi;
        logic in_lo;
        logic sel;
        in_hi = probe_addr >= high_start(prot_q[PROT_HS_LSB+:2]);
        in_lo = (probe_addr >= LOW_START) &&
                (probe_addr <= low_end(prot_q[PROT_LS_LSB+:2]));
        sel   = (!prot_q[PROT_HDIS] && in_hi) || (!prot_q[PROT_LDIS] && in_lo);
        if (!aresetn) begin
            prot_hit_q <= 1'b1;
        end else if (prot_q[PROT_POLARITY]) begin
            prot_hit_q <= sel;
        end else begin
            prot_hit_q <= !sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q <= CONFIG_RST;
        end else if (wr_fire && wstb_q && aw_idx_q == IDX_CONFIG) begin
            config_q <= {wd_q[CFG_BUFFER_EMPTY_IRQ_ENABLE], wd_q[CFG_COMPLETE_IRQ_ENABLE], 6'h00};
        end
    end

    // command sequence, one active plus one buffered command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buffer_empty_flag_q      <= 1'b1;
            command_complete_flag_q       <= 1'b1;
            seq_active_q <= 1'b0;
            busy_q       <= 1'b0;
            buffered_q   <= 1'b0;
            launch_q     <= 1'b0;
            blank_q      <= 1'b0;
        end else begin
            launch_q <= launch_ok;
            if (flash_word_wr && buffer_empty_flag_q) begin
                seq_active_q <= 1'b1;
            end
            if (abort) begin
                seq_active_q <= 1'b0;
            end
            if (launch_ok) begin
                buffer_empty_flag_q      <= 1'b0;
                command_complete_flag_q       <= 1'b0;
                blank_q      <= 1'b0;
                seq_active_q <= 1'b0;
                if (busy_q && !cmd_done) begin
                    buffered_q <= 1'b1;
                end else begin
                    busy_q <= 1'b1;
                end
            end else begin
                if (!buffer_empty_flag_q && !buffered_q) begin
                    buffer_empty_flag_q <= 1'b1;
                end
                if (cmd_done && busy_q) begin
                    if (buffered_q) begin
                        buffered_q <= 1'b0;
                        buffer_empty_flag_q    <= 1'b1;
                    end else begin
                        busy_q <= 1'b0;
                        command_complete_flag_q <= 1'b1;
                    end
                end
                if (cmd_blank) begin
                    blank_q <= 1'b1;
                end
            end
        end
    end

    // error flags: hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            protect_violation_flag_q  <= 1'b0;
            access_error_flag_q <= 1'b0;
            fail_q   <= 1'b0;
        end else begin
            if (cmd_violation) begin
                protect_violation_flag_q <= 1'b1;
            end else if (wr_stat && wd_q[STAT_PROTECT_VIOLATION_FLAG]) begin
                protect_violation_flag_q <= 1'b0;
            end
            if (abort) begin
                access_error_flag_q <= 1'b1;
            end else if (wr_stat && wd_q[STAT_ACC]) begin
                access_error_flag_q <= 1'b0;
            end
            if (cmd_fail && special_mode) begin
                fail_q <= 1'b1;
            end else if (wr_stat && wd_q[STAT_FAIL] && special_mode) begin
                fail_q <= 1'b0;
            end
        end
    end

    // sticky event bits, write-one clear, enable mask
    always_ff @(posedge aclk) begin
        logic [EV_W-1:0] ev_set;
        logic [EV_W-1:0] ev_clr;
        ev_set = '0;
        ev_set[EV_BUFFER_EMPTY_FLAG] = buffer_empty_flag_q && !buffer_empty_flag_prev_q;
        ev_set[EV_COMMAND_COMPLETE_FLAG]  = command_complete_flag_q && !command_complete_flag_prev_q;
        ev_set[EV_ACC]   = abort;
        ev_set[EV_PROTECT_VIOLATION_FLAG] = cmd_violation;
        ev_clr = (wr_fire && wstb_q && aw_idx_q == IDX_IRQ_CLR) ? wd_q[EV_W-1:0] : '0;
        if (!aresetn) begin
            ev_stat_q    <= '0;
            ev_en_q      <= '0;
            buffer_empty_flag_prev_q <= 1'b1;
            command_complete_flag_prev_q  <= 1'b1;
            irq_q        <= 1'b0;
        end else begin
            buffer_empty_flag_prev_q <= buffer_empty_flag_q;
            command_complete_flag_prev_q  <= command_complete_flag_q;
            ev_stat_q    <= (ev_stat_q & ~ev_clr) | ev_set;
            if (wr_fire && wstb_q && aw_idx_q == IDX_IRQ_EN) begin
                ev_en_q <= wd_q[EV_W-1:0];
            end
            irq_q <= (|(ev_stat_q & ev_en_q)) ||
                     (buffer_empty_flag_q && config_q[CFG_BUFFER_EMPTY_IRQ_ENABLE]) ||
                     (command_complete_flag_q && config_q[CFG_COMPLETE_IRQ_ENABLE]);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_prot_reject: assert property (wr_prot && !scen_allowed(scen_of(prot_q), scen_new)
        |=> prot_q == $past(prot_q)) else $error("disallowed protection write took effect");
    a_scen_step: assert property (!load_pending_q && !$past(load_pending_q)
        && $changed(prot_q) |-> scen_allowed(scen_of($past(prot_q)), scen_of(prot_q)))
        else $error("illegal protection scenario transition");
    a_low_size_hold: assert property (wr_prot && !prot_q[PROT_LDIS]
        |=> $stable(prot_q[PROT_LS_LSB+:2])) else $error("low size changed while enabled");
    a_high_size_hold: assert property (wr_prot && !prot_q[PROT_HDIS]
        |=> $stable(prot_q[PROT_HS_LSB+:2])) else $error("high size changed while enabled");
    a_full_protect: assert property (!prot_q[PROT_POLARITY] && prot_q[PROT_HDIS] &&
        prot_q[PROT_LDIS] |=> addr_protected) else $error("array not fully protected");
    a_no_protect: assert property (prot_q[PROT_POLARITY] && prot_q[PROT_HDIS] &&
        prot_q[PROT_LDIS] |=> !addr_protected) else $error("protection with both disabled");
    a_abort_err: assert property (abort |=> access_error_flag_q && !seq_active_q ##1 access_error_flag_q)
        else $error("abort did not raise access error");
    a_launch_clr: assert property (cmd_launch |-> !command_complete_flag_q && !buffer_empty_flag_q)
        else $error("launch left complete flag set");
    a_launch_block: assert property (access_error_flag_q || protect_violation_flag_q |=> !cmd_launch)
        else $error("launch while error flag set");
    a_irq_buf: assert property (buffer_empty_flag_q && config_q[CFG_BUFFER_EMPTY_IRQ_ENABLE] |=> irq)
        else $error("buffer empty interrupt missing");
    a_normal_read: assert property (arvalid && arready
        && araddr == {22'h0, IDX_STAT, 2'b00} && !special_mode
        |=> rdata[1:0] == 2'b00) else $error("fail/done visible in normal mode");

    c_launch: cover property (cmd_launch ##[1:20] command_complete_flag_q);
    c_abort: cover property (abort);
    c_buffered: cover property (launch_ok && busy_q && !cmd_done);
    c_prot_add: cover property (wr_prot ##1 $changed(prot_q));
    c_irq: cover property ($rose(irq));
endmodule

// File: tb/fps_testbench.sv
// self-checking bench for the flash protection and status block
// assumes fps_pkg and fps_flash_protect are compiled ahead of it
`timescale 1ns/1ns
module testbench
    import fps_pkg::*;
;
    localparam logic [7:0]  ok_tbl [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08,
                                          8'h18, 8'h3c, 8'h5a, 8'hff};
    localparam logic [15:0] hs_tbl [4] = '{16'hf800, 16'hf000, 16'he000, 16'hc000};
    localparam logic [15:0] le_tbl [4] = '{16'h43ff, 16'h47ff, 16'h4fff, 16'h5fff};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = '0;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'h1;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [31:0] araddr = '0;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic        special_mode = 1'b0;
    logic [7:0]  nv_protection = 8'hff;
    logic        flash_word_wr = 1'b0;
    logic        cmd_done = 1'b0;
    logic        cmd_fail = 1'b0;
    logic        cmd_blank = 1'b0;
    logic        cmd_violation = 1'b0;
    logic        cmd_launch;
    logic        cmd_active;
    logic [15:0] probe_addr = '0;
    logic        addr_protected;
    logic        irq;
    logic [1:0]  wresp;
    int          error_cnt = 0;
    int          checked = 0;
    int          launch_cnt = 0;
    int          seed = 93;

    fps_flash_protect DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .special_mode(special_mode), .nv_protection(nv_protection),
        .flash_word_wr(flash_word_wr), .cmd_done(cmd_done), .cmd_fail(cmd_fail),
        .cmd_blank(cmd_blank), .cmd_violation(cmd_violation), .cmd_launch(cmd_launch),
        .cmd_active(cmd_active), .probe_addr(probe_addr), .addr_protected(addr_protected),
        .irq(irq));

    always #4 aclk = ~aclk;

    always @(posedge aclk) begin
        if (cmd_launch === 1'b1) begin
            launch_cnt <= launch_cnt + 1;
        end
    end

    task automatic final_report();
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    // masters hold valid until the edge where ready was seen high
    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        logic pa;
        logic pw;
        logic ta;
        logic tw;
        logic v;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        v = 1'b0;
        while (!(ta && tw)) begin
            @(negedge aclk);
            pa = awready;
            pw = wready;
            @(posedge aclk);
            if (!ta && pa) begin
                awvalid <= 1'b0;
                ta = 1'b1;
            end
            if (!tw && pw) begin
                wvalid <= 1'b0;
                tw = 1'b1;
            end
        end
        bready <= 1'b1;
        while (!v) begin
            @(negedge aclk);
            v = bvalid;
            wresp = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic p;
        logic v;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        p = 1'b0;
        v = 1'b0;
        while (!p) begin
            @(negedge aclk);
            p = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        rready <= 1'b1;
        while (!v) begin
            @(negedge aclk);
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end
        rready <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(name, exp, d);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask

    // 0 word write, 1 done, 2 violation, 3 fail, 4 blank
    task automatic pulse(input int k);
        @(posedge aclk);
        flash_word_wr <= (k == 0);
        cmd_done <= (k == 1);
        cmd_violation <= (k == 2);
        cmd_fail <= (k == 3);
        cmd_blank <= (k == 4);
        @(posedge aclk);
        {flash_word_wr, cmd_done, cmd_violation, cmd_fail, cmd_blank} <= 5'h00;
        repeat (2) @(posedge aclk);
    endtask

    task automatic do_reset(input logic [7:0] nv, input logic sp);
        @(posedge aclk);
        aresetn <= 1'b0;
        nv_protection <= nv;
        special_mode <= sp;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    function automatic logic [7:0] prot_next(input logic [7:0] o, input logic [7:0] w);
        logic [7:0] r;
        r = o;
        if (ok_tbl[{o[7], o[5], o[2]}][{w[7], w[5], w[2]}]) begin
            {r[7], r[5], r[2]} = {w[7], w[5], w[2]};
            r[4:3] = o[5] ? w[4:3] : o[4:3];
            r[1:0] = o[2] ? w[1:0] : o[1:0];
        end
        return r;
    endfunction

    function automatic logic prot_of(input logic [7:0] p, input logic [15:0] a);
        logic hit;
        hit = (!p[5] && a >= hs_tbl[p[4:3]]) || (!p[2] && a >= 16'h4000 && a <= le_tbl[p[1:0]]);
        return p[7] ? hit : !hit;
    endfunction

    initial begin
        #(8 * 40000);
        error_cnt++;
        final_report();
    end

    initial begin
        logic [31:0] rnd;
        logic [7:0]  nv;
        logic [7:0]  w;
        logic [7:0]  e;
        logic [15:0] pa [5];
        logic [31:0] d;
        logic [1:0]  r;
        logic [31:0] s;
        s = ba(IDX_STAT);
        // every source scenario against every target, sizes at random
        for (int f = 0; f < 8; f++) begin
            for (int t = 0; t < 8; t++) begin
                rnd = $random(seed);
                nv = {f[2], rnd[0], f[1], rnd[2:1], f[0], rnd[4:3]};
                w = {t[2], rnd[5], t[1], rnd[7:6], t[0], rnd[9:8]};
                do_reset(nv, 1'b0);
                rchk("prot_nv", ba(IDX_PROT), {24'h0, nv});
                wreg(ba(IDX_PROT), {24'h0, w});
                e = prot_next(nv, w);
                rchk("prot_new", ba(IDX_PROT), {24'h0, e});
                pa = '{hs_tbl[e[4:3]] - 16'h1, hs_tbl[e[4:3]], le_tbl[e[1:0]],
                       le_tbl[e[1:0]] + 16'h1, rnd[31:16]};
                for (int k = 0; k < 5; k++) begin
                    @(posedge aclk);
                    probe_addr <= pa[k];
                    repeat (2) @(posedge aclk);
                    @(negedge aclk);
                    chk("addr_protected", prot_of(e, pa[k]), addr_protected);
                end
            end
        end
        do_reset(8'hff, 1'b0);
        rchk("stat_rst", s, 32'hc0);
        pulse(3);
        wreg(s, 32'h02);
        rchk("stat_nofail", s, 32'hc0);
        pulse(4);
        wreg(s, 32'h00);
        rchk("stat_idle_wr0", s, 32'hc4);
        wreg(ba(IDX_CONFIG), 32'h40);
        @(negedge aclk);
        chk("irq_idle", 1, irq);
        pulse(0);
        wreg(s, 32'h80);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("irq_run", 0, irq);
        chk("cmd_active", 1, cmd_active);
        rchk("stat_run", s, 32'h80);
        wreg(ba(IDX_CONFIG), 32'h80);
        pulse(0);
        wreg(s, 32'h80);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("irq_buf", 0, irq);
        rchk("stat_buf", s, 32'h00);
        pulse(1);
        rchk("stat_fetch", s, 32'h80);
        @(negedge aclk);
        chk("irq_fetch", 1, irq);
        pulse(1);
        rchk("stat_done", s, 32'hc0);
        @(negedge aclk);
        chk("cmd_active_end", 0, cmd_active);
        chk("launches", 2, launch_cnt);
        wreg(ba(IDX_CONFIG), 32'h00);
        wreg(ba(IDX_IRQ_CLR), 32'h0f);
        wreg(ba(IDX_IRQ_EN), 32'h04);
        pulse(2);
        pulse(0);
        wreg(s, 32'h80);
        rchk("stat_viol", s, 32'he0);
        chk("launch_blocked", 2, launch_cnt);
        @(negedge aclk);
        chk("irq_masked", 0, irq);
        wreg(s, 32'h00);
        rchk("stat_abort", s, 32'hf0);
        @(negedge aclk);
        chk("irq_event", 1, irq);
        rchk("event_stat", ba(IDX_IRQ_STAT), 32'h0c);
        wreg(s, 32'h30);
        rchk("stat_clear", s, 32'hc0);
        wreg(ba(IDX_IRQ_CLR), 32'h0c);
        chk("bresp_okay", {30'h0, RESP_OKAY}, {30'h0, wresp});
        rchk("event_clr", ba(IDX_IRQ_STAT), 32'h00);
        @(negedge aclk);
        chk("irq_clr", 0, irq);
        rd(32'h0000_003c, d, r);
        chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        wreg(ba(IDX_PROT) + 32'h1, 32'h00);
        chk("misaligned_bresp", {30'h0, RESP_SLVERR}, {30'h0, wresp});
        rchk("prot_misaligned", ba(IDX_PROT), 32'hff);
        wreg(32'h0000_0410, 32'h00);
        chk("range_bresp", {30'h0, RESP_SLVERR}, {30'h0, wresp});
        rchk("prot_range", ba(IDX_PROT), 32'hff);
        do_reset(8'hff, 1'b1);
        rchk("stat_special", s, 32'hc1);
        pulse(3);
        rchk("stat_fail", s, 32'hc3);
        wreg(s, 32'h02);
        rchk("stat_fail_clr", s, 32'hc1);
        final_report();
    end
endmodule
